/* rtl/iap_flash_ctrl.sv */
// flash programming controller with axi4-lite register slave
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module iap_flash_ctrl
    import iap_pkg::*;
#(
    parameter int PROG_CYC = PROG_CYC_DEF,
    parameter int UNLOCK_CYC = UNLOCK_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output iap_fl_cmd_t fl_cmd,
    input wire logic [15:0] fl_rdata,
    output logic cpu_stall,
    output logic chip_reset
);
    logic aw_got, w_got, wlane;
    logic [7:0] waddr, wbyte, rd_val;
    logic wr_fire, w_hit, ar_hit, wr_en;
    logic wr_main, wr_key, wr_wipe, wr_d0h;
    logic granted, unlock_trig, prog_go, fetch_en, fetch_go;
    logic [2:0] op_sel;
    logic [7:0] rst_key;
    logic buffer_wipe;
    logic [12:0] addr_reg;
    logic [7:0] dreg [0:7];
    logic [15:0] wbuf [0:PAGE_WORDS-1];
    logic [PAGE_WORDS-1:0] word_valid;
    iap_state_t state, next_state;
    logic [14:0] tmr;
    logic idle, key_ok, unlock_end, op_end, read_end, grant_set;
    logic go_unlock, go_erase, go_prog, go_read;
    logic clr_unlock, clr_prog, clr_fetch;

    // decode of a completed write; bytes sit in lane 0, other lanes ignored
    assign wr_fire = aw_got && w_got && !bvalid;
    assign w_hit = (waddr[1:0] == 2'h0) && (waddr <= OFS_D3H);
    assign ar_hit = (araddr[1:0] == 2'h0) && (araddr <= OFS_D3H);
    assign wr_en = wr_fire && wlane && w_hit;
    assign wr_main = wr_en && (waddr == OFS_MAIN);
    assign wr_key = wr_en && (waddr == OFS_RSTKEY);
    assign wr_wipe = wr_en && (waddr == OFS_WIPE);
    assign wr_d0h = wr_en && (waddr == OFS_D0H);

    // write address/data taken in either order, one response after both
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            waddr <= 8'h00;
            wbyte <= 8'h00;
            wlane <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                waddr <= awaddr;
                aw_got <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wbyte <= wdata[7:0];
                wlane <= wstrb[0];
                w_got <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= w_hit ? RESP_OKAY : RESP_SLVERR;
                aw_got <= 1'b0;
                w_got <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // read mux; unused upper bits and unmapped words read zero
    always_comb begin
        rd_val = 8'h00;
        case (araddr)
            OFS_MAIN: rd_val = {granted, op_sel, unlock_trig, prog_go, fetch_en, fetch_go};
            OFS_RSTKEY: rd_val = rst_key;
            OFS_WIPE: rd_val = {7'h00, buffer_wipe};
            OFS_ADDRL: rd_val = addr_reg[7:0];
            OFS_ADDRH: rd_val = {3'h0, addr_reg[12:8]};
            OFS_D0L: rd_val = dreg[0];
            OFS_D0H: rd_val = dreg[1];
            OFS_D1L: rd_val = dreg[2];
            OFS_D1H: rd_val = dreg[3];
            OFS_D2L: rd_val = dreg[4];
            OFS_D2H: rd_val = dreg[5];
            OFS_D3L: rd_val = dreg[6];
            OFS_D3H: rd_val = dreg[7];
            default: rd_val = 8'h00;
        endcase
    end

    // read channel answers one cycle after the address is taken
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h0, rd_val};
            rresp <= ar_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // sequencer decisions; one operation at a time, unlock first
    assign idle = (state == S_IDLE);
    assign key_ok = (dreg[2] == KEY1L) && (dreg[4] == KEY2L) && (dreg[6] == KEY3L) &&
                    (dreg[3] == KEY1H) && (dreg[5] == KEY2H) && (dreg[7] == KEY3H);
    assign unlock_end = (state == S_UNLOCK) && (tmr == 15'(UNLOCK_CYC - 1));
    assign op_end = ((state == S_ERASE) || (state == S_PROG)) && (tmr == 15'(PROG_CYC - 1));
    assign read_end = (state == S_READ) && (tmr == 15'(READ_CYC - 1));
    // key judged only at expiry, so late bytes never grant
    assign grant_set = unlock_end && key_ok;
    assign go_unlock = idle && unlock_trig && (op_sel == OP_UNLOCK);
    assign go_erase = idle && !unlock_trig && prog_go && granted && (op_sel == OP_ERASE);
    assign go_prog = idle && !unlock_trig && prog_go && granted && (op_sel == OP_WRITE);
    assign go_read = idle && !unlock_trig && !prog_go && fetch_go && fetch_en && (op_sel == OP_READ);
    // a trigger that cannot start is dropped at once instead of hanging
    assign clr_unlock = unlock_end || (idle && unlock_trig && !go_unlock);
    assign clr_prog = op_end || (idle && !unlock_trig && prog_go && !go_erase && !go_prog);
    assign clr_fetch = read_end || (idle && !unlock_trig && !prog_go && fetch_go && !go_read);

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (go_unlock) begin
                    next_state = S_UNLOCK;
                end else if (go_erase) begin
                    next_state = S_ERASE;
                end else if (go_prog) begin
                    next_state = S_PROG;
                end else if (go_read) begin
                    next_state = S_READ;
                end
            end
            S_UNLOCK: next_state = unlock_end ? S_IDLE : S_UNLOCK;
            S_ERASE: next_state = op_end ? S_IDLE : S_ERASE;
            S_PROG: next_state = op_end ? S_IDLE : S_PROG;
            S_READ: next_state = read_end ? S_IDLE : S_READ;
            default: next_state = S_IDLE;
        endcase
    end

    // state, timer and cpu hold; unlock does not stall the cpu
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= S_IDLE;
            tmr <= 15'h0;
            cpu_stall <= 1'b0;
        end else begin
            state <= next_state;
            tmr <= (next_state != state) ? 15'h0 : tmr + 15'h1;
            cpu_stall <= (next_state != S_IDLE) && (next_state != S_UNLOCK);
        end
    end

    // main control; hardware set of the grant wins over a software clear
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            granted <= 1'b0;
            op_sel <= 3'h0;
            unlock_trig <= 1'b0;
            prog_go <= 1'b0;
            fetch_en <= 1'b0;
            fetch_go <= 1'b0;
        end else begin
            if (clr_unlock) unlock_trig <= 1'b0;
            if (clr_prog) prog_go <= 1'b0;
            if (clr_fetch) fetch_go <= 1'b0;
            if (wr_main) begin
                op_sel <= wbyte[6:4];
                unlock_trig <= wbyte[BIT_UNLOCK];
                prog_go <= wbyte[BIT_PROG];
                fetch_en <= wbyte[BIT_FEN];
                fetch_go <= wbyte[BIT_FGO];
                if (!wbyte[BIT_GRANT]) granted <= 1'b0;
            end
            if (grant_set) granted <= 1'b1;
        end
    end

    // chip reset key, one-cycle reset request on the magic value
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rst_key <= REG_RST;
            chip_reset <= 1'b0;
        end else begin
            if (wr_key) rst_key <= wbyte;
            chip_reset <= wr_key && (wbyte == RST_KEY_VAL);
        end
    end

    // wipe bit self clears one cycle after it is set
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            buffer_wipe <= 1'b0;
        end else if (wr_wipe) begin
            buffer_wipe <= wbyte[BIT_WIPE];
        end else begin
            buffer_wipe <= 1'b0;
        end
    end

    // address pair; stops at the last word of the page
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            addr_reg <= 13'h0;
        end else if (wr_en && (waddr == OFS_ADDRL)) begin
            addr_reg[7:0] <= wbyte;
        end else if (wr_en && (waddr == OFS_ADDRH)) begin
            addr_reg[12:8] <= wbyte[4:0];
        end else if (wr_d0h && (addr_reg[4:0] != 5'h1F)) begin
            addr_reg <= addr_reg + 13'h1;
        end
    end

    // data registers; a finished read lands in the first pair
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) dreg[i] <= REG_RST;
        end else if (read_end) begin
            dreg[0] <= fl_rdata[7:0];
            dreg[1] <= fl_rdata[15:8];
        end else if (wr_en && (waddr >= OFS_D0L)) begin
            dreg[3'((waddr - OFS_D0L) >> 2)] <= wbyte;
        end
    end

    // buffer words carry no reset; only their valid bits do
    always_ff @(posedge clk_sys) begin
        if (wr_d0h) wbuf[addr_reg[4:0]] <= {wbyte, dreg[0]};
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            word_valid <= '0;
        end else begin
            if (buffer_wipe || (op_end && (state == S_PROG))) word_valid <= '0;
            // a load in the wipe cycle survives, the set wins
            if (wr_d0h) word_valid[addr_reg[4:0]] <= 1'b1;
        end
    end

    // flash commands; page words stream out in the first 32 cycles
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            fl_cmd <= '0;
        end else begin
            fl_cmd <= '0;
            if (go_erase) begin
                fl_cmd.erase <= 1'b1;
                fl_cmd.addr <= {addr_reg[12:5], 5'h00};
            end else if (go_read) begin
                fl_cmd.rd <= 1'b1;
                fl_cmd.addr <= addr_reg;
            end else if ((state == S_PROG) && (tmr[14:5] == 10'h0) && word_valid[tmr[4:0]]) begin
                fl_cmd.we <= 1'b1;
                fl_cmd.addr <= {addr_reg[12:5], tmr[4:0]};
                fl_cmd.wdata <= wbuf[tmr[4:0]];
            end
        end
    end

    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    AST_OP_NEEDS_GRANT: assert property ($rose(state == S_ERASE || state == S_PROG) |-> $past(granted))
        else $error("erase or write started without grant");
    AST_UNLOCK_RUN: assert property (go_unlock |=> (state == S_UNLOCK) && unlock_trig)
        else $error("unlock trigger did not start timer");
    AST_UNLOCK_END: assert property (unlock_end |=> !unlock_trig && (state == S_IDLE))
        else $error("unlock trigger not cleared at expiry");
    AST_GRANT_CAUSE: assert property ($rose(granted) |-> $past(unlock_end && key_ok))
        else $error("grant rose without correct key at expiry");
    AST_DISABLE: assert property (wr_main && !wbyte[BIT_GRANT] && !grant_set |=> !granted)
        else $error("grant not dropped by software clear");
    AST_PROG_DONE: assert property (op_end |=> !prog_go && (state == S_IDLE) && !cpu_stall)
        else $error("program_go not cleared at end");
    AST_READ_GATE: assert property (idle && fetch_go && !fetch_en && !unlock_trig && !prog_go
        |=> idle && !fetch_go && !fl_cmd.rd)
        else $error("read ran while disabled");
    AST_READ_LEN: assert property (go_read |=> (state == S_READ && fetch_go && cpu_stall)[*3]
        ##1 (idle && !fetch_go))
        else $error("read length wrong");
    AST_STALL: assert property (!idle && (state != S_UNLOCK) |-> cpu_stall)
        else $error("cpu not stalled during operation");
    AST_CHIP_RST: assert property (wr_key && (wbyte == RST_KEY_VAL) |=> chip_reset ##1 !chip_reset)
        else $error("chip reset pulse missing");
    AST_WIPE: assert property (buffer_wipe && !wr_en |=> (word_valid == '0) && !buffer_wipe)
        else $error("buffer wipe incomplete");
    AST_NO_GRANT: assert property (idle && prog_go && !granted && !unlock_trig
        |=> idle && !prog_go && !fl_cmd.erase)
        else $error("ungranted erase or write not ignored");

    COV_GRANT: cover property (grant_set);
    COV_PROG: cover property (op_end && (state == S_PROG) && (word_valid != '0));
    COV_READ: cover property (read_end);
endmodule

/* rtl/iap_pkg.sv */
// constants, types and behaviour list of the flash programming controller
// Function
// - op code 110 unlocks; erase/write need unlock
// - unlock trigger starts timer; cleared on expiry
// - expiry clears unlock trigger whatever key
// - correct key sets modify_granted, wrong leaves low
// - writing zero to modify_granted disables at once
// - program_go starts erase/write, cleared when done
// - fetch_enable low blocks every read
// - fetch_go starts read, cleared when read done
// - cpu stalled while read/erase/write runs
// - writing 55H to reset key resets chip
// - buffer_wipe empties buffer, self clears, bits7~1 zero
// - buffer holds 32 words, page from bits 12~5
// - erased page reads back as 0000h
// - op codes: 000 write, 001 erase, 011 read
// - high byte write loads word, bumps address; the code holds it at the last word of the page
// - buffer cleared automatically after write finishes
// - erase/write keeps program_go high 2.2ms
package iap_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFS_MAIN = 8'h00;
    localparam logic [7:0] OFS_RSTKEY = 8'h04;
    localparam logic [7:0] OFS_WIPE = 8'h08;
    localparam logic [7:0] OFS_ADDRL = 8'h0C;
    localparam logic [7:0] OFS_ADDRH = 8'h10;
    localparam logic [7:0] OFS_D0L = 8'h14;
    localparam logic [7:0] OFS_D0H = 8'h18;
    localparam logic [7:0] OFS_D1L = 8'h1C;
    localparam logic [7:0] OFS_D1H = 8'h20;
    localparam logic [7:0] OFS_D2L = 8'h24;
    localparam logic [7:0] OFS_D2H = 8'h28;
    localparam logic [7:0] OFS_D3L = 8'h2C;
    localparam logic [7:0] OFS_D3H = 8'h30;
    // field positions in the main control register and the wipe register
    localparam int BIT_GRANT = 7;
    localparam int BIT_UNLOCK = 3;
    localparam int BIT_PROG = 2;
    localparam int BIT_FEN = 1;
    localparam int BIT_FGO = 0;
    localparam int BIT_WIPE = 0;
    // operation select codes
    localparam logic [2:0] OP_WRITE = 3'h0;
    localparam logic [2:0] OP_ERASE = 3'h1;
    localparam logic [2:0] OP_READ = 3'h3;
    localparam logic [2:0] OP_UNLOCK = 3'h6;
    // unlock key, low bytes of pairs 1..3 then high bytes
    localparam logic [7:0] KEY1L = 8'h00;
    localparam logic [7:0] KEY2L = 8'h0D;
    localparam logic [7:0] KEY3L = 8'hC3;
    localparam logic [7:0] KEY1H = 8'h04;
    localparam logic [7:0] KEY2H = 8'h09;
    localparam logic [7:0] KEY3H = 8'h40;
    localparam logic [7:0] RST_KEY_VAL = 8'h55;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing
    localparam real CLK_MHZ = 10.0;
    localparam real PROG_TIME_MS = 2.2;
    localparam int PROG_CYC_DEF = $rtoi(PROG_TIME_MS * CLK_MHZ * 1000.0);
    localparam int UNLOCK_CYC_DEF = 256;
    localparam int READ_CYC = 3;
    localparam int PAGE_WORDS = 32;

    typedef struct packed {
        logic erase;
        logic we;
        logic rd;
        logic [12:0] addr;
        logic [15:0] wdata;
    } iap_fl_cmd_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_UNLOCK = 5'h02,
        S_ERASE = 5'h04,
        S_PROG = 5'h08,
        S_READ = 5'h10
    } iap_state_t;
endpackage

/* test/iap_flash_model.sv */
// behavioural flash array facing the programming controller
`timescale 1ns/1ps
module iap_flash_model
    import iap_pkg::*;
(
    input wire logic clk_sys,
    input iap_fl_cmd_t fl_cmd,
    output logic [15:0] fl_rdata
);
    logic [15:0] mem [0:8191];
    logic [12:0] raddr;
    logic [2:0] rpipe;

    // non-blank start pattern so that an erase is visible
    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = 16'hA5A5;
        raddr = 13'h0000;
        rpipe = 3'h0;
    end

    // erase blanks the whole addressed page, write stores one word
    always @(posedge clk_sys) begin
        if (fl_cmd.erase) begin
            for (int i = 0; i < 32; i++) mem[{fl_cmd.addr[12:5], i[4:0]}] <= 16'h0000;
        end
        if (fl_cmd.we) mem[fl_cmd.addr] <= fl_cmd.wdata;
        if (fl_cmd.rd) raddr <= fl_cmd.addr;
        rpipe <= {rpipe[1:0], fl_cmd.rd};
    end

    // data only holds for three cycles after a read; outside that it is inverted
    assign fl_rdata = (|rpipe) ? mem[raddr] : ~mem[raddr];
endmodule

/* test/testbench.sv */
// self-checking bench for the flash programming controller
`timescale 1ns/1ps
module testbench
    import iap_pkg::*;
;
    localparam int PCYC = 40;
    localparam logic [7:0] KOFS [6] = '{OFS_D1L, OFS_D2L, OFS_D3L, OFS_D1H, OFS_D2H, OFS_D3H};
    localparam logic [7:0] KVAL [6] = '{KEY1L, KEY2L, KEY3L, KEY1H, KEY2H, KEY3H};
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, cpu_stall, chip_reset;
    logic [1:0] bresp, rresp, wresp, lresp;
    // lane strobe offered by the write task; lane 0 off means the write is dropped
    logic [3:0] strb_use = 4'hF;
    logic [31:0] rdata;
    logic [15:0] fl_rdata;
    iap_fl_cmd_t fl_cmd;
    int err_count = 0, num_checks = 0, cyc = 0;
    int n_erase = 0, n_we = 0, n_rd = 0, n_rst = 0, stall_cyc = 0, base;

    always #50 clk_sys = ~clk_sys;

    iap_flash_ctrl #(.PROG_CYC(PCYC), .UNLOCK_CYC(64)) DUT (.clk_sys(clk_sys), .rstn(rstn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .fl_cmd(fl_cmd), .fl_rdata(fl_rdata),
        .cpu_stall(cpu_stall), .chip_reset(chip_reset));
    iap_flash_model flash (.clk_sys(clk_sys), .fl_cmd(fl_cmd), .fl_rdata(fl_rdata));

    // event counters for flash commands, chip reset and cpu stall; a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cyc++;
        if (fl_cmd.erase === 1'b1) n_erase++;
        if (fl_cmd.we === 1'b1) n_we++;
        if (fl_cmd.rd === 1'b1) n_rd++;
        if (chip_reset === 1'b1) n_rst++;
        if (cpu_stall === 1'b1) stall_cyc <= stall_cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // address and data offered together, each released once taken
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk_sys);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= strb_use;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk_sys);
            if (!ad && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk_sys);
        wresp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk_sys);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        logic [1:0] r;
        axr(a, v, r);
        lresp = r;
        chk({8'h00, v}, {8'h00, e});
    endtask

    // wait until the device drops one bit of the main control register
    task automatic poll(input int b);
        logic [7:0] v;
        logic [1:0] r;
        v = 8'hFF;
        for (int k = 0; k < 400 && v[b] !== 1'b0; k++) axr(OFS_MAIN, v, r);
    endtask

    // enable and go bits go in separate writes
    task automatic fread(input logic [12:0] a, input logic [7:0] g, input logic [15:0] e);
        logic [7:0] lo;
        logic [7:0] hi;
        logic [1:0] r;
        axw(OFS_ADDRL, a[7:0]);
        axw(OFS_ADDRH, {3'h0, a[12:8]});
        axw(OFS_MAIN, g | 8'h32);
        stall_cyc = 0;
        axw(OFS_MAIN, g | 8'h33);
        poll(0);
        axr(OFS_D0L, lo, r);
        axr(OFS_D0H, hi, r);
        chk({hi, lo}, e);
    endtask

    // six key bytes, low bytes first; bad corrupts the last one
    task automatic unlock(input logic bad, input logic late);
        axw(OFS_MAIN, 8'h68);
        if (late) poll(3);
        for (int k = 0; k < 6; k++) axw(KOFS[k], KVAL[k] ^ {7'h00, bad && k == 5});
    endtask

    task automatic ldw(input logic [15:0] d);
        axw(OFS_D0L, d[7:0]);
        axw(OFS_D0H, d[15:8]);
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        rc(OFS_MAIN, 8'h00);
        rc(OFS_RSTKEY, 8'h00);
        rc(OFS_WIPE, 8'h00);
        chk({14'h0, lresp}, {14'h0, RESP_OKAY});
        rc(8'h34, 8'h00);
        chk({14'h0, lresp}, {14'h0, RESP_SLVERR});
        axw(8'h40, 8'hFF);
        chk({14'h0, wresp}, {14'h0, RESP_SLVERR});
        axw(OFS_ADDRL, 8'h20);
        axw(OFS_MAIN, 8'h14);
        poll(2);
        rc(OFS_MAIN, 8'h10);
        chk(16'(n_erase), 16'h0000);
        unlock(1'b1, 1'b0);
        poll(3);
        rc(OFS_MAIN, 8'h60);
        unlock(1'b0, 1'b1);
        rc(OFS_MAIN, 8'h60);
        unlock(1'b0, 1'b0);
        rc(OFS_MAIN, 8'h68);
        poll(3);
        rc(OFS_MAIN, 8'hE0);
        stall_cyc = 0;
        axw(OFS_MAIN, 8'h94);
        poll(2);
        chk(16'(stall_cyc), 16'(PCYC));
        chk(16'(n_erase), 16'h0001);
        rc(OFS_MAIN, 8'h90);
        fread(13'h0025, 8'h80, 16'h0000);
        chk(16'(stall_cyc), 16'(READ_CYC));
        axw(OFS_ADDRL, 8'h22);
        ldw(16'h2211);
        rc(OFS_ADDRL, 8'h23);
        axw(OFS_WIPE, 8'h01);
        rc(OFS_WIPE, 8'h00);
        axw(OFS_ADDRL, 8'h20);
        ldw(16'h3412);
        ldw(16'h7856);
        axw(OFS_MAIN, 8'h84);
        poll(2);
        chk(16'(n_we), 16'h0002);
        rc(OFS_MAIN, 8'h80);
        fread(13'h0020, 8'h80, 16'h3412);
        fread(13'h0021, 8'h80, 16'h7856);
        fread(13'h0022, 8'h80, 16'h0000);
        axw(OFS_MAIN, 8'h84);
        poll(2);
        chk(16'(n_we), 16'h0002);
        base = n_rd;
        axw(OFS_MAIN, 8'hB1);
        poll(0);
        chk(16'(n_rd - base), 16'h0000);
        // reserved operation codes start nothing even with permission
        foreach (KOFS[k]) begin
            if (k < 4) begin
                axw(OFS_MAIN, {1'b1, 3'(k == 0 ? 2 : k == 3 ? 7 : k + 3), 4'h4});
                poll(2);
                rc(OFS_MAIN, {1'b1, 3'(k == 0 ? 2 : k == 3 ? 7 : k + 3), 4'h0});
            end
        end
        chk(16'(n_erase + n_we), 16'h0003);
        axw(OFS_MAIN, 8'h00);
        rc(OFS_MAIN, 8'h00);
        axw(OFS_MAIN, 8'h14);
        poll(2);
        chk(16'(n_erase), 16'h0001);
        fread(13'h0020, 8'h00, 16'h3412);
        axw(OFS_RSTKEY, 8'h54);
        // the reset value on a write whose lane 0 strobe is off must do nothing
        strb_use = 4'hE;
        axw(OFS_RSTKEY, 8'h55);
        strb_use = 4'hF;
        chk({14'h0, wresp}, {14'h0, RESP_OKAY});
        rc(OFS_RSTKEY, 8'h54);
        chk(16'(n_rst), 16'h0000);
        axw(OFS_RSTKEY, 8'h55);
        repeat (4) @(posedge clk_sys);
        chk(16'(n_rst), 16'h0001);
        summarize();
    end
endmodule
